//--- fcc_params.svh
// constants for the flash command controller, both ends
// assumes inclusion by bare name from the package and modules
// What this block does
// - array is 32 pages of 512 bytes
// - address from high/low regs, data via data reg
// - access key 0x3B must precede a command
// - access key returns to 0xFF after operation
// - core stalls until the operation finishes
// - interrupts wait until the operation completes
// - timers keep running during flash operations
// - code 1 programs data byte into flash
// - code 2 erases the addressed 512-byte page
// - code 3 erases whole array, guards ignored
// - code 4 reads addressed byte into data reg
// - code 5 erases page then programs byte
// - code 8 commits protection regs into flash
// - protection update needs key match at 0x3FFA
// - stored key 0xFF skips the key comparison
// - key plus code 8 stores key, once only
// - protection active only if last page guarded
// - erased reads 0xFF, programming clears bits only
// - cleared guard bit protects, set bit unprotects
`ifndef FCC_PARAMS_SVH
`define FCC_PARAMS_SVH
`define FCC_ADDR_CMD 8'hB9
`define FCC_ADDR_KEY 8'hBA
`define FCC_ADDR_PKEY 8'hBB
`define FCC_ADDR_DATA 8'hBC
`define FCC_ADDR_WG_LO 8'hBD
`define FCC_ADDR_WG_MID 8'hBE
`define FCC_ADDR_RG 8'hBF
`define FCC_ADDR_ADRL 8'hC6
`define FCC_ADDR_ADRH 8'hC7
`define FCC_RST_ZERO 8'h00
`define FCC_RST_ONES 8'hFF
`define FCC_ACCESS_KEY 8'h3B
`define FCC_CMD_WRITE 8'h01
`define FCC_CMD_ERASE_PAGE 8'h02
`define FCC_CMD_ERASE_ALL 8'h03
`define FCC_CMD_READ 8'h04
`define FCC_CMD_ERASE_WRITE 8'h05
`define FCC_CMD_PROTECT 8'h08
`define FCC_BYTES 16384
`define FCC_AW 14
`define FCC_PAGES 32
`define FCC_PAGE_LSB 9
`define FCC_PAGE_LAST_IDX 14'h01FF
`define FCC_ARRAY_LAST_IDX 14'h3FFF
`define FCC_PKEY_LOC 14'h3FFA
`define FCC_RG_LOC 14'h3FFB
`define FCC_WG_LOC0 14'h3FFC
`define FCC_WG_LOC1 14'h3FFD
`define FCC_WG_LOC2 14'h3FFE
`define FCC_WG_LOC3 14'h3FFF
`define FCC_PROT_LAST_IDX 14'h0005
`define FCC_LAST_PAGE_BIT 7
`define FCC_GROUP_LSB 2
`endif

//--- fcc_pkg.sv
// types shared by both ends of the flash command controller
// assumes fcc_params.svh is on the include path
package fcc_pkg;
	`include "fcc_params.svh"
	typedef logic [7:0] fcc_byte_t;
	typedef logic [`FCC_AW-1:0] fcc_addr_t;
	typedef enum logic [2:0] {
		FCC_ST_IDLE = 3'b000,
		FCC_ST_ERASE = 3'b001,
		FCC_ST_PROG = 3'b010,
		FCC_ST_READ = 3'b011,
		FCC_ST_PROT = 3'b100,
		FCC_ST_DONE = 3'b101
	} fcc_state_e;
	typedef enum logic [3:0] {
		FCC_H_IDLE = 4'b0000,
		FCC_H_ADL = 4'b0001,
		FCC_H_ADH = 4'b0010,
		FCC_H_DAT = 4'b0011,
		FCC_H_CMD = 4'b0100,
		FCC_H_GAP = 4'b0101,
		FCC_H_WAIT = 4'b0110,
		FCC_H_RWAIT = 4'b0111
	} fcc_host_e;
endpackage

//--- fcc_sfr_if.sv
// special function register link between core and flash controller
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface fcc_sfr_if;
	logic [7:0] sfr_addr;
	logic [7:0] sfr_wdata;
	logic sfr_we;
	logic sfr_re;
	logic [7:0] sfr_rdata;
	logic sfr_rvalid;
	logic flash_busy;
	modport device (
		input sfr_addr, sfr_wdata, sfr_we, sfr_re,
		output sfr_rdata, sfr_rvalid, flash_busy
	);
	modport core (
		output sfr_addr, sfr_wdata, sfr_we, sfr_re,
		input sfr_rdata, sfr_rvalid, flash_busy
	);
endinterface

//--- fcc_device.sv
// flash controller end: register file, command sequencer, array
// assumes the core holds its bus quiet while flash_busy is high
`timescale 1ns/1ps
module fcc_device (
	input wire logic mclk, // core clock
	input wire logic rstn, // async reset, active low
	fcc_sfr_if.device bus, // register link to the core
	output fcc_pkg::fcc_state_e state, // sequencer state
	output logic prot_active // protection scheme in force
);
	import fcc_pkg::*;

	fcc_state_e state_ff;
	fcc_byte_t cmd_ff, key_ff, pkey_ff, data_ff, wg_lo_ff, wg_mid_ff, rg_ff, adrl_ff, adrh_ff;
	fcc_byte_t rdata_ff;
	logic rvalid_ff;
	fcc_addr_t idx_ff, last_ff;
	logic prog_after_ff;
	logic skip_ff;
	fcc_byte_t mem_ff [`FCC_BYTES];
	fcc_addr_t flash_addr;
	logic [4:0] page;
	logic [31:0] wg_bits;
	logic page_guarded, group_guarded, prot_ok, cmd_wr, key_ok;
	logic mem_we, mem_erase;
	fcc_addr_t mem_idx;
	fcc_byte_t mem_val, prot_val;

	assign flash_addr = {adrh_ff[`FCC_AW-9:0], adrl_ff};
	assign page = flash_addr[`FCC_AW-1:`FCC_PAGE_LSB];
	assign wg_bits = {mem_ff[`FCC_WG_LOC3], mem_ff[`FCC_WG_LOC2],
		mem_ff[`FCC_WG_LOC1], mem_ff[`FCC_WG_LOC0]};
	// stored guard of page 31 must be cleared before any write or read guard is enforced; the stored key check applies regardless
	assign prot_active = ~wg_bits[`FCC_PAGES-1];
	assign page_guarded = prot_active & ~wg_bits[page];
	assign group_guarded = prot_active & ~mem_ff[`FCC_RG_LOC][page[4:`FCC_GROUP_LSB]];
	assign prot_ok = (mem_ff[`FCC_PKEY_LOC] == `FCC_RST_ONES)
		| (pkey_ff == mem_ff[`FCC_PKEY_LOC]);
	assign cmd_wr = bus.sfr_we & (bus.sfr_addr == `FCC_ADDR_CMD) & (state_ff == FCC_ST_IDLE);
	assign key_ok = (key_ff == `FCC_ACCESS_KEY);
	assign bus.flash_busy = (state_ff != FCC_ST_IDLE);
	assign bus.sfr_rdata = rdata_ff;
	assign bus.sfr_rvalid = rvalid_ff;
	assign state = state_ff;

	always_comb begin
		case (idx_ff[2:0])
			3'd0: prot_val = pkey_ff;
			3'd1: prot_val = rg_ff;
			3'd2: prot_val = wg_lo_ff;
			3'd3: prot_val = wg_mid_ff;
			3'd4: prot_val = adrl_ff;
			default: prot_val = adrh_ff;
		endcase
	end

	always_comb begin
		mem_we = 1'b0;
		mem_erase = 1'b0;
		mem_idx = idx_ff;
		mem_val = data_ff;
		case (state_ff)
			FCC_ST_ERASE: begin
				mem_we = 1'b1;
				mem_erase = 1'b1;
			end
			// refused targets pass through here too, so a refused command stays busy two cycles like a byte write
			FCC_ST_PROG: begin
				mem_we = !skip_ff;
				mem_idx = flash_addr;
			end
			FCC_ST_PROT: begin
				mem_we = 1'b1;
				mem_idx = `FCC_PKEY_LOC + idx_ff;
				mem_val = prot_val;
			end
			default: mem_we = 1'b0;
		endcase
	end

	// array starts blank so a fresh model behaves like an erased part
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < `FCC_BYTES; i++) begin
				mem_ff[i] <= `FCC_RST_ONES;
			end
		end else if (mem_we) begin
			if (mem_erase) begin
				mem_ff[mem_idx] <= `FCC_RST_ONES;
			end else begin
				mem_ff[mem_idx] <= mem_ff[mem_idx] & mem_val;
			end
		end
	end

	// sequencer; commands are only taken while idle
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= FCC_ST_IDLE;
			idx_ff <= '0;
			last_ff <= '0;
			prog_after_ff <= 1'b0;
			skip_ff <= 1'b0;
		end else begin
			case (state_ff)
				FCC_ST_IDLE: begin
					prog_after_ff <= 1'b0;
					skip_ff <= 1'b0;
					if (cmd_wr && key_ok) begin
						case (bus.sfr_wdata)
							`FCC_CMD_WRITE: begin
								state_ff <= FCC_ST_PROG;
								skip_ff <= page_guarded;
							end
							`FCC_CMD_ERASE_PAGE, `FCC_CMD_ERASE_WRITE: begin
								idx_ff <= {page, {`FCC_PAGE_LSB{1'b0}}};
								last_ff <= {page, {`FCC_PAGE_LSB{1'b0}}} | `FCC_PAGE_LAST_IDX;
								prog_after_ff <= (bus.sfr_wdata == `FCC_CMD_ERASE_WRITE);
								state_ff <= page_guarded ? FCC_ST_PROG : FCC_ST_ERASE;
								skip_ff <= page_guarded;
							end
							`FCC_CMD_ERASE_ALL: begin
								idx_ff <= '0;
								last_ff <= `FCC_ARRAY_LAST_IDX;
								state_ff <= FCC_ST_ERASE;
							end
							`FCC_CMD_READ: begin
								state_ff <= FCC_ST_READ;
							end
							`FCC_CMD_PROTECT: begin
								idx_ff <= '0;
								state_ff <= prot_ok ? FCC_ST_PROT : FCC_ST_PROG;
								skip_ff <= !prot_ok;
							end
							default: state_ff <= FCC_ST_IDLE;
						endcase
					end
				end
				FCC_ST_ERASE: begin
					if (idx_ff == last_ff) begin
						state_ff <= prog_after_ff ? FCC_ST_PROG : FCC_ST_DONE;
					end else begin
						idx_ff <= idx_ff + 1'b1;
					end
				end
				FCC_ST_PROG: state_ff <= FCC_ST_DONE;
				FCC_ST_READ: state_ff <= FCC_ST_DONE;
				FCC_ST_PROT: begin
					if (idx_ff == `FCC_PROT_LAST_IDX) begin
						state_ff <= FCC_ST_DONE;
					end else begin
						idx_ff <= idx_ff + 1'b1;
					end
				end
				FCC_ST_DONE: state_ff <= FCC_ST_IDLE;
				default: state_ff <= FCC_ST_IDLE;
			endcase
		end
	end

	// access key: cleared after every operation and after a refused command
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			key_ff <= `FCC_RST_ONES;
		end else if (state_ff == FCC_ST_DONE || cmd_wr) begin
			key_ff <= `FCC_RST_ONES;
		end else if (bus.sfr_we && bus.sfr_addr == `FCC_ADDR_KEY && state_ff == FCC_ST_IDLE) begin
			key_ff <= bus.sfr_wdata;
		end
	end

	// data register also captures read results
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			data_ff <= `FCC_RST_ZERO;
		end else if (state_ff == FCC_ST_READ) begin
			if (!group_guarded) begin
				data_ff <= mem_ff[flash_addr];
			end
		end else if (bus.sfr_we && bus.sfr_addr == `FCC_ADDR_DATA && state_ff == FCC_ST_IDLE) begin
			data_ff <= bus.sfr_wdata;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cmd_ff <= `FCC_RST_ZERO;
			pkey_ff <= `FCC_RST_ONES;
			wg_lo_ff <= `FCC_RST_ONES;
			wg_mid_ff <= `FCC_RST_ONES;
			rg_ff <= `FCC_RST_ONES;
			adrl_ff <= `FCC_RST_ZERO;
			adrh_ff <= `FCC_RST_ZERO;
		end else if (bus.sfr_we && state_ff == FCC_ST_IDLE) begin
			case (bus.sfr_addr)
				`FCC_ADDR_CMD: cmd_ff <= bus.sfr_wdata;
				`FCC_ADDR_PKEY: pkey_ff <= bus.sfr_wdata;
				`FCC_ADDR_WG_LO: wg_lo_ff <= bus.sfr_wdata;
				`FCC_ADDR_WG_MID: wg_mid_ff <= bus.sfr_wdata;
				`FCC_ADDR_RG: rg_ff <= bus.sfr_wdata;
				`FCC_ADDR_ADRL: adrl_ff <= bus.sfr_wdata;
				`FCC_ADDR_ADRH: adrh_ff <= bus.sfr_wdata;
				default: cmd_ff <= cmd_ff;
			endcase
		end
	end

	// register read answers one cycle after the strobe
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rdata_ff <= `FCC_RST_ZERO;
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= bus.sfr_re;
			if (bus.sfr_re) begin
				case (bus.sfr_addr)
					`FCC_ADDR_CMD: rdata_ff <= cmd_ff;
					`FCC_ADDR_KEY: rdata_ff <= key_ff;
					`FCC_ADDR_PKEY: rdata_ff <= pkey_ff;
					`FCC_ADDR_DATA: rdata_ff <= data_ff;
					`FCC_ADDR_WG_LO: rdata_ff <= wg_lo_ff;
					`FCC_ADDR_WG_MID: rdata_ff <= wg_mid_ff;
					`FCC_ADDR_RG: rdata_ff <= rg_ff;
					`FCC_ADDR_ADRL: rdata_ff <= adrl_ff;
					`FCC_ADDR_ADRH: rdata_ff <= adrh_ff;
					default: rdata_ff <= `FCC_RST_ZERO;
				endcase
			end
		end
	end
endmodule

//--- fcc_core.sv
// core end: runs flash command sequences, holds interrupts, keeps a timer
// assumes the device answers reads one cycle after the strobe
`timescale 1ns/1ps
module fcc_core (
	input wire logic mclk, // core clock
	input wire logic rstn, // async reset, active low
	fcc_sfr_if.core bus, // register link to the controller
	input wire logic cmd_start, // pulse: run a flash command
	input wire logic [7:0] cmd_code, // command code
	input wire logic [13:0] cmd_addr, // flash byte address
	input wire logic [7:0] cmd_data, // byte to program
	input wire logic [7:0] cmd_key, // value loaded into access key
	input wire logic sfr_wr, // pulse: single register write
	input wire logic [7:0] sfr_wr_addr, // register address for sfr_wr
	input wire logic [7:0] sfr_wr_data, // data for sfr_wr
	output logic ready, // idle, may take a request
	output logic done, // pulse: sequence finished
	output logic [7:0] rd_data, // byte returned by a read command
	input wire logic irq_event, // pulse: interrupt request
	output logic irq_service, // pulse: interrupt taken
	output logic [15:0] timer_count // free-running timer
);
	import fcc_pkg::*;

	fcc_host_e st_ff;
	logic [7:0] addr_ff, wdata_ff, code_ff, rd_ff;
	logic we_ff, re_ff, done_ff, pend_ff, svc_ff;
	logic [13:0] fa_ff;
	logic [7:0] fd_ff;
	logic [15:0] tmr_ff;

	assign bus.sfr_addr = addr_ff;
	assign bus.sfr_wdata = wdata_ff;
	assign bus.sfr_we = we_ff;
	assign bus.sfr_re = re_ff;
	assign ready = (st_ff == FCC_H_IDLE) & ~we_ff;
	assign done = done_ff;
	assign rd_data = rd_ff;
	assign irq_service = svc_ff;
	assign timer_count = tmr_ff;

	// timer never looks at the stall so it runs through flash operations
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tmr_ff <= 16'h0000;
		end else begin
			tmr_ff <= tmr_ff + 16'h0001;
		end
	end

	// set wins over the service clear
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pend_ff <= 1'b0;
			svc_ff <= 1'b0;
		end else begin
			svc_ff <= pend_ff & ~bus.flash_busy & ~svc_ff;
			pend_ff <= irq_event | (pend_ff & ~(~bus.flash_busy & ~svc_ff));
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_ff <= FCC_H_IDLE;
			addr_ff <= 8'h00;
			wdata_ff <= 8'h00;
			we_ff <= 1'b0;
			re_ff <= 1'b0;
			done_ff <= 1'b0;
			code_ff <= 8'h00;
			fa_ff <= 14'h0000;
			fd_ff <= 8'h00;
			rd_ff <= 8'h00;
		end else begin
			we_ff <= 1'b0;
			re_ff <= 1'b0;
			done_ff <= 1'b0;
			case (st_ff)
				FCC_H_IDLE: begin
					if (cmd_start && !we_ff) begin
						we_ff <= 1'b1;
						addr_ff <= `FCC_ADDR_KEY;
						wdata_ff <= cmd_key;
						code_ff <= cmd_code;
						fa_ff <= cmd_addr;
						fd_ff <= cmd_data;
						st_ff <= FCC_H_ADL;
					end else if (sfr_wr && !we_ff) begin
						we_ff <= 1'b1;
						addr_ff <= sfr_wr_addr;
						wdata_ff <= sfr_wr_data;
					end
				end
				FCC_H_ADL: begin
					we_ff <= 1'b1;
					addr_ff <= `FCC_ADDR_ADRL;
					wdata_ff <= fa_ff[7:0];
					st_ff <= FCC_H_ADH;
				end
				FCC_H_ADH: begin
					we_ff <= 1'b1;
					addr_ff <= `FCC_ADDR_ADRH;
					wdata_ff <= {2'b00, fa_ff[13:8]};
					st_ff <= FCC_H_DAT;
				end
				FCC_H_DAT: begin
					we_ff <= 1'b1;
					addr_ff <= `FCC_ADDR_DATA;
					wdata_ff <= fd_ff;
					st_ff <= FCC_H_CMD;
				end
				FCC_H_CMD: begin
					we_ff <= 1'b1;
					addr_ff <= `FCC_ADDR_CMD;
					wdata_ff <= code_ff;
					st_ff <= FCC_H_GAP;
				end
				// one cycle for the controller to raise its stall
				FCC_H_GAP: st_ff <= FCC_H_WAIT;
				FCC_H_WAIT: begin
					if (!bus.flash_busy) begin
						if (code_ff == `FCC_CMD_READ) begin
							re_ff <= 1'b1;
							addr_ff <= `FCC_ADDR_DATA;
							st_ff <= FCC_H_RWAIT;
						end else begin
							done_ff <= 1'b1;
							st_ff <= FCC_H_IDLE;
						end
					end
				end
				FCC_H_RWAIT: begin
					if (bus.sfr_rvalid) begin
						rd_ff <= bus.sfr_rdata;
						done_ff <= 1'b1;
						st_ff <= FCC_H_IDLE;
					end
				end
				default: st_ff <= FCC_H_IDLE;
			endcase
		end
	end
endmodule

//--- fcc_checker_assertions.sv
// checker for the sfr link between core and flash controller
// assumes one clock; the bench instantiates it beside the interface
`timescale 1ns/1ps
`include "fcc_params.svh"
module fcc_checker_assertions (
	input wire logic mclk, // core clock
	input wire logic rstn, // async reset, active low
	input wire logic [7:0] sfr_addr, // register address
	input wire logic [7:0] sfr_wdata, // write data
	input wire logic sfr_we, // write strobe
	input wire logic sfr_re, // read strobe
	input wire logic [7:0] sfr_rdata, // read data
	input wire logic sfr_rvalid, // read data valid
	input wire logic flash_busy // operation in progress
);
	logic key_ok_ff;
	logic [7:0] cmd_ff;
	logic [15:0] run_ff;
	logic cmd_wr;
	logic code_ok;
	logic cmd_acc;
	assign cmd_wr = sfr_we && !flash_busy && sfr_addr == `FCC_ADDR_CMD;
	assign code_ok = sfr_wdata inside {`FCC_CMD_WRITE, `FCC_CMD_ERASE_PAGE, `FCC_CMD_ERASE_ALL,
		`FCC_CMD_READ, `FCC_CMD_ERASE_WRITE, `FCC_CMD_PROTECT};
	assign cmd_acc = cmd_wr && key_ok_ff && code_ok;
	// any command write spends the key, taken or refused
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			key_ok_ff <= 1'b0;
		else if (sfr_we && !flash_busy && sfr_addr == `FCC_ADDR_KEY)
			key_ok_ff <= sfr_wdata == `FCC_ACCESS_KEY;
		else if (cmd_wr)
			key_ok_ff <= 1'b0;
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			cmd_ff <= 8'h00;
		else if (cmd_acc)
			cmd_ff <= sfr_wdata;
	end
	// length of the current busy run, read at the falling edge of busy
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			run_ff <= 16'h0000;
		else if (flash_busy)
			run_ff <= run_ff + 16'h0001;
		else
			run_ff <= 16'h0000;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	sequence s_short_op;
		flash_busy [*2] ##1 !flash_busy;
	endsequence
	sequence s_refused;
		!flash_busy ##1 !flash_busy;
	endsequence
	a_write_len: assert property (cmd_acc && sfr_wdata == `FCC_CMD_WRITE |=> s_short_op)
		else $error("byte write busy length wrong");
	a_read_len: assert property (cmd_acc && sfr_wdata == `FCC_CMD_READ |=> s_short_op)
		else $error("byte read busy length wrong");
	a_long_start: assert property (cmd_acc && sfr_wdata inside {`FCC_CMD_ERASE_PAGE,
		`FCC_CMD_ERASE_ALL, `FCC_CMD_ERASE_WRITE, `FCC_CMD_PROTECT} |=> flash_busy [*2])
		else $error("accepted command did not hold busy");
	a_refused_idle: assert property (cmd_wr && !(key_ok_ff && code_ok) |=> s_refused)
		else $error("command ran without key or with unknown code");
	a_page_erase_len: assert property ($fell(flash_busy) && cmd_ff == `FCC_CMD_ERASE_PAGE
		|-> run_ff inside {16'h0201, 16'h0002})
		else $error("page erase length wrong");
	a_mass_erase_len: assert property ($fell(flash_busy) && cmd_ff == `FCC_CMD_ERASE_ALL
		|-> run_ff == 16'h4001)
		else $error("mass erase length wrong");
	a_erase_write_len: assert property ($fell(flash_busy) && cmd_ff == `FCC_CMD_ERASE_WRITE
		|-> run_ff inside {16'h0202, 16'h0002})
		else $error("erase then write length wrong");
	a_protect_len: assert property ($fell(flash_busy) && cmd_ff == `FCC_CMD_PROTECT
		|-> run_ff inside {16'h0007, 16'h0002})
		else $error("protect command length wrong");
	a_read_answer: assert property (sfr_re |=> sfr_rvalid)
		else $error("register read not answered next cycle");
endmodule

//--- test_flash_command_controller.sv
// self-checking bench: core and flash controller joined by the sfr link
// assumes package, header, interface, both ends and checker compiled first
`timescale 1ns/1ps
`include "fcc_params.svh"
module test_flash_command_controller;
	import fcc_pkg::*;
	logic mclk, rstn, cmd_start, sfr_wr, irq_event, ready, done, irq_service, prot_active;
	logic [7:0] cmd_code, cmd_data, cmd_key, sfr_wr_addr, sfr_wr_data, rd_data;
	logic [13:0] cmd_addr;
	logic [15:0] timer_count;
	fcc_state_e state;
	int err_total, n_compared;
	fcc_sfr_if bus_if();
	fcc_device u_fcc_device (.mclk(mclk), .rstn(rstn), .bus(bus_if.device), .state(state),
		.prot_active(prot_active));
	fcc_core u_fcc_core (.mclk(mclk), .rstn(rstn), .bus(bus_if.core), .cmd_start(cmd_start),
		.cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_key(cmd_key),
		.sfr_wr(sfr_wr), .sfr_wr_addr(sfr_wr_addr), .sfr_wr_data(sfr_wr_data), .ready(ready),
		.done(done), .rd_data(rd_data), .irq_event(irq_event), .irq_service(irq_service),
		.timer_count(timer_count));
	fcc_checker_assertions u_fcc_checker_assertions (.mclk(mclk), .rstn(rstn),
		.sfr_addr(bus_if.sfr_addr), .sfr_wdata(bus_if.sfr_wdata), .sfr_we(bus_if.sfr_we),
		.sfr_re(bus_if.sfr_re), .sfr_rdata(bus_if.sfr_rdata), .sfr_rvalid(bus_if.sfr_rvalid),
		.flash_busy(bus_if.flash_busy));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tend(input string name);
		$display("test %s done, mismatches %0d", name, err_total);
	endtask
	task automatic wait_ready();
		for (int i = 0; i < 8 && ready !== 1'b1; i++)
			@(negedge mclk);
		if (ready !== 1'b1) begin
			err_total++;
			$display("[ERR] %0t core never ready", $time);
			tally_and_finish();
		end
	endtask
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		wait_ready();
		sfr_wr = 1'b1;
		sfr_wr_addr = addr;
		sfr_wr_data = data;
		@(negedge mclk);
		sfr_wr = 1'b0;
		@(negedge mclk);
	endtask
	// every run also checks the timer kept counting while the core stalled
	task automatic run(input logic [7:0] code, input logic [13:0] addr,
		input logic [7:0] data, input logic [7:0] key, input logic irq);
		int n;
		int in_busy;
		int irq_cnt;
		logic fired;
		logic [15:0] t0;
		n = 0;
		in_busy = 0;
		irq_cnt = 0;
		fired = 1'b0;
		wait_ready();
		cmd_start = 1'b1;
		cmd_code = code;
		cmd_addr = addr;
		cmd_data = data;
		cmd_key = key;
		t0 = timer_count;
		do begin
			@(negedge mclk);
			n++;
			cmd_start = 1'b0;
			irq_event = irq && bus_if.flash_busy === 1'b1 && !fired;
			fired = fired | irq_event;
			in_busy += int'(bus_if.flash_busy === 1'b1 && irq_service === 1'b1);
			irq_cnt += int'(irq_service === 1'b1);
		end while (done !== 1'b1 && n < 20000);
		irq_event = 1'b0;
		if (done !== 1'b1) begin
			err_total++;
			$display("[ERR] %0t command never finished", $time);
			tally_and_finish();
		end
		check({13'h0000, state}, {13'h0000, FCC_ST_IDLE});
		check(timer_count - t0, n[15:0]);
		if (irq) begin
			repeat (4) begin
				@(negedge mclk);
				irq_cnt += int'(irq_service === 1'b1);
			end
			check(16'(in_busy), 16'h0000);
			check(16'(irq_cnt), 16'h0001);
		end
	endtask
	task automatic rd(input logic [13:0] addr, input logic [7:0] exp);
		run(`FCC_CMD_READ, addr, 8'h00, `FCC_ACCESS_KEY, 1'b0);
		@(negedge mclk);
		check({8'h00, rd_data}, {8'h00, exp});
	endtask
	initial begin
		err_total = 0;
		n_compared = 0;
		rstn = 1'b0;
		{cmd_start, sfr_wr, irq_event} = 3'b000;
		{cmd_code, cmd_data, cmd_key, sfr_wr_addr, sfr_wr_data} = 40'h0;
		cmd_addr = 14'h0000;
		repeat (16) @(negedge mclk);
		rstn = 1'b1;
		rd(14'h0123, 8'hFF);
		run(`FCC_CMD_WRITE, 14'h0123, 8'h5A, `FCC_ACCESS_KEY, 1'b1);
		rd(14'h0123, 8'h5A);
		run(`FCC_CMD_WRITE, 14'h0123, 8'hF0, `FCC_ACCESS_KEY, 1'b0);
		rd(14'h0123, 8'h50);
		tend("program");
		// wrong key, then unknown code: both must leave the byte alone
		run(`FCC_CMD_WRITE, 14'h0123, 8'h00, 8'h3A, 1'b0);
		run(8'h07, 14'h0123, 8'h00, `FCC_ACCESS_KEY, 1'b0);
		rd(14'h0123, 8'h50);
		tend("refused");
		run(`FCC_CMD_WRITE, 14'h0200, 8'h11, `FCC_ACCESS_KEY, 1'b0);
		run(`FCC_CMD_ERASE_PAGE, 14'h01FF, 8'h00, `FCC_ACCESS_KEY, 1'b1);
		rd(14'h0123, 8'hFF);
		rd(14'h0200, 8'h11);
		run(`FCC_CMD_ERASE_WRITE, 14'h0200, 8'h22, `FCC_ACCESS_KEY, 1'b0);
		rd(14'h0200, 8'h22);
		tend("erase");
		wr(`FCC_ADDR_PKEY, 8'hA5);
		run(`FCC_CMD_PROTECT, 14'h0000, 8'h00, `FCC_ACCESS_KEY, 1'b0);
		rd(`FCC_PKEY_LOC, 8'hA5);
		check({15'h0000, prot_active}, 16'h0001);
		run(`FCC_CMD_WRITE, 14'h2000, 8'h00, `FCC_ACCESS_KEY, 1'b0);
		rd(14'h2000, 8'hFF);
		wr(`FCC_ADDR_PKEY, 8'h00);
		run(`FCC_CMD_PROTECT, 14'h0000, 8'h00, `FCC_ACCESS_KEY, 1'b0);
		rd(`FCC_PKEY_LOC, 8'hA5);
		tend("protect");
		run(`FCC_CMD_ERASE_ALL, 14'h0000, 8'h00, `FCC_ACCESS_KEY, 1'b0);
		rd(`FCC_PKEY_LOC, 8'hFF);
		check({15'h0000, prot_active}, 16'h0000);
		tend("mass erase");
		tally_and_finish();
	end
endmodule
